// file: src/clear_and_call_instr_exec.sv
// executes clear-file, clear-accumulator, clear-guard and call instructions
// assumes one opcode per instruction cycle on CLK_I; other instructions
// only advance the program counter here, their effects live elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "clear_call_regs.svh"

module clear_and_call_instr_exec
#(
	parameter int PC_WIDTH   = 13,
	parameter int ADDR_WIDTH = 7,
	parameter int DATA_WIDTH = 8
)
(
	input  wire logic                           CLK_I,
	input  wire logic                           RESET_I,
	input  wire logic                           OP_VALID_I,
	input  wire logic [13:0]                    OPCODE_I,
	input  wire logic [4:0]                     PC_UPPER_LATCH_I,
	input  wire logic                           GUARD_EXPIRED_I,
	input  wire logic                           SLEEP_ENTERED_I,
	output var  logic [12:0]                    PC_O,
	output var  logic [7:0]                     ACCUM_O,
	output var  logic                           ZERO_FLAG_O,
	output var  clear_call_pkg::file_write_type FILE_WR_O,
	output var  clear_call_pkg::stack_push_type STACK_PUSH_O,
	output var  logic                           FLUSH_O,
	output var  logic                           GUARD_CLEAR_O,
	output var  logic                           PRESCALE_CLEAR_O,
	output var  logic                           EXPIRY_FLAG_N_O,
	output var  logic                           POWERDOWN_FLAG_N_O
);
	import clear_call_pkg::*;

	// the structs and field defines fix these widths
	if (PC_WIDTH != 13 || ADDR_WIDTH != 7 || DATA_WIDTH != 8)
	begin : bad_width
		$error("clear_and_call_instr_exec: widths must be 13, 7 and 8");
	end

	typedef enum logic {ST_EXEC, ST_FLUSH} state_type;

	state_type   state;
	state_type   next_state;
	op_kind_type kind;
	logic [12:0] next_pc;
	logic [12:0] pc_plus_one;
	logic [12:0] call_target;
	logic        exec_ok;
	logic        do_clr_file;
	logic        do_clr_acc;
	logic        do_clr_guard;
	logic        do_call;
	logic        do_step;

	clear_call_decode u_decode
	(
		.opcode_i (OPCODE_I),
		.kind_o   (kind)
	);

	// sequential successor, kept to the counter width
	function automatic logic [12:0] pc_inc(input logic [12:0] pc);
		return 13'(pc + 13'h0001);
	endfunction : pc_inc

	// qualify the decode: the flush cycle ignores whatever was fetched
	assign exec_ok      = OP_VALID_I && (state == ST_EXEC); // [RULE_05]
	assign do_clr_file  = exec_ok && (kind == OP_CLR_FILE);
	assign do_clr_acc   = exec_ok && (kind == OP_CLR_ACC);
	assign do_clr_guard = exec_ok && (kind == OP_CLR_GUARD);
	assign do_call      = exec_ok && (kind == OP_CALL);
	assign do_step      = exec_ok && (kind != OP_CALL);

	// next pc: pc plus one, or on a call page bits from the latch, page offset from the opcode
	assign pc_plus_one = pc_inc(PC_O); // [RULE_02]
	assign call_target = {PC_UPPER_LATCH_I[`LATCH_PAGE_MSB:`LATCH_PAGE_LSB],
		OPCODE_I[`CALL_TARGET_MSB:0]}; // [RULE_03] [RULE_04]
	assign next_pc    = do_call ? call_target : (do_step ? pc_plus_one : PC_O);
	assign next_state = do_call ? ST_FLUSH : ST_EXEC; // [RULE_05]

	// sequencing: a call spends one extra cycle discarding the prefetch
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			state   <= ST_EXEC;
			PC_O    <= `PC_RESET;
			FLUSH_O <= 1'b0;
		end
		else
		begin
			state   <= next_state;
			PC_O    <= next_pc; // [RULE_10]
			FLUSH_O <= do_call; // [RULE_05]
		end
	end

	// accumulator and zero flag; only the clears touch them here
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			ACCUM_O     <= `ACCUM_RESET;
			ZERO_FLAG_O <= `ZERO_RESET;
		end
		else
		begin
			if (do_clr_acc)
				ACCUM_O <= `CLEARED_DATA; // [RULE_06]
			if (do_clr_acc || do_clr_file)
				ZERO_FLAG_O <= 1'b1; // [RULE_01] [RULE_06]
		end
	end

	// one-cycle write and push strobes
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			FILE_WR_O    <= '0;
			STACK_PUSH_O <= '0;
		end
		else
		begin
			FILE_WR_O.strobe    <= do_clr_file; // [RULE_01]
			FILE_WR_O.addr      <= OPCODE_I[`FILE_ADDR_MSB:0];
			FILE_WR_O.data      <= `CLEARED_DATA;
			STACK_PUSH_O.strobe <= do_call; // [RULE_02]
			STACK_PUSH_O.addr   <= pc_plus_one;
		end
	end

	// guard timer side: counter and prescaler cleared together
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			GUARD_CLEAR_O    <= 1'b0;
			PRESCALE_CLEAR_O <= 1'b0;
		end
		else
		begin
			GUARD_CLEAR_O    <= do_clr_guard; // [RULE_07]
			PRESCALE_CLEAR_O <= do_clr_guard; // [RULE_08]
		end
	end

	// active-low status; an expiry or sleep event in the same cycle
	// wins so that a real event is never masked by a late clear
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			EXPIRY_FLAG_N_O    <= `STATUS_N_RESET;
			POWERDOWN_FLAG_N_O <= `STATUS_N_RESET;
		end
		else
		begin
			if (GUARD_EXPIRED_I)
				EXPIRY_FLAG_N_O <= 1'b0;
			else if (do_clr_guard)
				EXPIRY_FLAG_N_O <= 1'b1; // [RULE_09]
			if (SLEEP_ENTERED_I)
				POWERDOWN_FLAG_N_O <= 1'b0;
			else if (do_clr_guard)
				POWERDOWN_FLAG_N_O <= 1'b1; // [RULE_09]
		end
	end

	// checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	sequence call_taken;
		do_call;
	endsequence

	sequence flush_then_exec;
		FLUSH_O && !FILE_WR_O.strobe && !GUARD_CLEAR_O ##1 !FLUSH_O && state == ST_EXEC;
	endsequence

	sequence clear_taken;
		do_clr_file || do_clr_acc || do_clr_guard;
	endsequence

	clr_file_write_a: assert property ( // [RULE_01]
		do_clr_file |=> FILE_WR_O.strobe && FILE_WR_O.data == `CLEARED_DATA
			&& FILE_WR_O.addr == $past(OPCODE_I[6:0]) && ZERO_FLAG_O)
		else $error("clear file did not write zero with zero flag");

	call_push_a: assert property ( // [RULE_02]
		call_taken |=> STACK_PUSH_O.strobe
			&& STACK_PUSH_O.addr == pc_inc($past(PC_O)))
		else $error("call did not push the return address");

	call_target_a: assert property ( // [RULE_03]
		call_taken |=> PC_O[10:0] == $past(OPCODE_I[10:0]))
		else $error("call target not loaded into low pc");

	call_page_a: assert property ( // [RULE_04]
		call_taken |=> PC_O[12:11] == $past(PC_UPPER_LATCH_I[4:3]))
		else $error("call page bits not taken from latch");

	call_two_cycle_a: assert property ( // [RULE_05]
		call_taken |=> flush_then_exec)
		else $error("call did not take exactly two cycles");

	flush_hold_a: assert property ( // [RULE_05]
		FLUSH_O |=> $stable(PC_O) && !STACK_PUSH_O.strobe)
		else $error("discarded prefetch changed state");

	clr_acc_a: assert property ( // [RULE_06]
		do_clr_acc |=> ACCUM_O == `CLEARED_DATA && ZERO_FLAG_O && !FILE_WR_O.strobe)
		else $error("clear accumulator failed");

	guard_clear_a: assert property ( // [RULE_07]
		do_clr_guard |=> GUARD_CLEAR_O ##1 !GUARD_CLEAR_O || $past(do_clr_guard))
		else $error("guard clear pulse wrong");

	// both clears must follow the decode one cycle later, never on their own
	prescale_pair_a: assert property ( // [RULE_08]
		1'b1 |=> PRESCALE_CLEAR_O == $past(do_clr_guard)
			&& GUARD_CLEAR_O == PRESCALE_CLEAR_O)
		else $error("prescaler clear not paired with counter clear");

	status_set_a: assert property ( // [RULE_09]
		do_clr_guard && !GUARD_EXPIRED_I && !SLEEP_ENTERED_I
			|=> EXPIRY_FLAG_N_O && POWERDOWN_FLAG_N_O
			&& $stable(ZERO_FLAG_O) && $stable(ACCUM_O))
		else $error("guard clear did not set status flags only");

	single_cycle_a: assert property ( // [RULE_10]
		clear_taken |=> !FLUSH_O && PC_O == pc_inc($past(PC_O)))
		else $error("clear instruction not single cycle");

endmodule : clear_and_call_instr_exec
`default_nettype wire

// file: src/clear_call_decode.sv
// opcode decoder for the clear and call execution block
// assumes a 14-bit opcode presented combinationally
`timescale 1ns/1ps
`default_nettype none
`include "clear_call_regs.svh"

module clear_call_decode
(
	input  wire logic [13:0]              opcode_i,
	output var  clear_call_pkg::op_kind_type kind_o
);
	import clear_call_pkg::*;

	// prefix matches, the guard clear is a full-word compare
	function automatic op_kind_type decode(input logic [13:0] op);
		op_kind_type k;
		k = OP_OTHER;
		if (op == `CLR_GUARD_OPCODE)
			k = OP_CLR_GUARD; // [RULE_07]
		else if (op[`CLR_PREFIX_MSB:`CLR_PREFIX_LSB] == `CLR_FILE_PREFIX)
			k = OP_CLR_FILE; // [RULE_01]
		else if (op[`CLR_PREFIX_MSB:`CLR_PREFIX_LSB] == `CLR_ACC_PREFIX)
			k = OP_CLR_ACC; // low bits are don't-care [RULE_06]
		else if (op[`CALL_PREFIX_MSB:`CALL_PREFIX_LSB] == `CALL_PREFIX)
			k = OP_CALL; // [RULE_03]
		return k;
	endfunction : decode

	assign kind_o = decode(opcode_i);

endmodule : clear_call_decode
`default_nettype wire

// file: src/clear_call_pkg.sv
// types shared by the clear and call execution block
// assumes the constants header sets the field widths used here
package clear_call_pkg;

	// decoded instruction kinds
	typedef enum logic [2:0] {
		OP_OTHER,
		OP_CLR_FILE,
		OP_CLR_ACC,
		OP_CLR_GUARD,
		OP_CALL
	} op_kind_type;

	// file register write port towards the register file
	typedef struct packed {
		logic       strobe;
		logic [6:0] addr;
		logic [7:0] data;
	} file_write_type;

	// push port towards the return stack
	typedef struct packed {
		logic        strobe;
		logic [12:0] addr;
	} stack_push_type;

endpackage : clear_call_pkg

// file: src/clear_call_regs.svh
// constants for the clear and call execution block: opcodes, fields, resets, timing
// assumes a 14-bit program word and a 13-bit program counter
// Functional notes
// (RULE_01) clear file op zeroes register, sets zero
// (RULE_02) call pushes program counter plus one first
// (RULE_03) call loads 11-bit target into pc 10:0
// (RULE_04) call loads pc 12:11 from latch 4:3
// (RULE_05) call takes two cycles, fetched word discarded
// (RULE_06) clear accumulator op zeroes it, sets zero
// (RULE_07) clear guard op zeroes guard timer count
// (RULE_08) clear guard op also zeroes the prescaler
// (RULE_09) clear guard op sets both active-low status flags; an expiry or sleep event in the same cycle drops its flag instead
// (RULE_10) clear ops take one cycle, one word
`ifndef CLEAR_CALL_REGS_SVH
`define CLEAR_CALL_REGS_SVH

// opcode fields
`define CLR_FILE_PREFIX    7'h03
`define CLR_ACC_PREFIX     7'h02
`define CLR_PREFIX_MSB     13
`define CLR_PREFIX_LSB     7
`define FILE_ADDR_MSB      6
`define CLR_GUARD_OPCODE   14'h0064
`define CALL_PREFIX        3'h4
`define CALL_PREFIX_MSB    13
`define CALL_PREFIX_LSB    11
`define CALL_TARGET_MSB    10
`define LATCH_PAGE_MSB     4
`define LATCH_PAGE_LSB     3

// reset values
`define PC_RESET           13'h0000
`define ACCUM_RESET        8'h00
`define ZERO_RESET         1'h0
`define STATUS_N_RESET     1'h1
`define CLEARED_DATA       8'h00

// timing
`define CLK_PERIOD_NS      20
`define CALL_CYCLES        2
`define CLEAR_CYCLES       1

`endif

// file: tb/testbench.sv
// self-checking bench for the clear and call execution block
// assumes the design package and constants header are compiled first
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import clear_call_pkg::*;

	logic           clk_i;
	logic           reset_i;
	logic           op_valid_i;
	logic [13:0]    opcode_i;
	logic [4:0]     latch_i;
	logic           expired_i;
	logic           sleep_i;
	logic [12:0]    pc_o;
	logic [7:0]     accum_o;
	logic           zero_o;
	file_write_type file_wr_o;
	stack_push_type push_o;
	logic           flush_o;
	logic           guard_clr_o;
	logic           pre_clr_o;
	logic           expiry_n_o;
	logic           pdown_n_o;
	// behavioural model of what the outputs must show after the next edge
	int             m_pc, m_acc, m_z, m_fl, m_wr, m_wa, m_push, m_pa, m_gc, m_e, m_p;
	int             fail_count;
	int             total_checks;
	logic           armed;
	logic [15:0]    seed;

	clear_and_call_instr_exec i_dut (
		.CLK_I              (clk_i),
		.RESET_I            (reset_i),
		.OP_VALID_I         (op_valid_i),
		.OPCODE_I           (opcode_i),
		.PC_UPPER_LATCH_I   (latch_i),
		.GUARD_EXPIRED_I    (expired_i),
		.SLEEP_ENTERED_I    (sleep_i),
		.PC_O               (pc_o),
		.ACCUM_O            (accum_o),
		.ZERO_FLAG_O        (zero_o),
		.FILE_WR_O          (file_wr_o),
		.STACK_PUSH_O       (push_o),
		.FLUSH_O            (flush_o),
		.GUARD_CLEAR_O      (guard_clr_o),
		.PRESCALE_CLEAR_O   (pre_clr_o),
		.EXPIRY_FLAG_N_O    (expiry_n_o),
		.POWERDOWN_FLAG_N_O (pdown_n_o)
	);

	// free-running 50 MHz clock
	always #10 clk_i = ~clk_i;

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	// one cycle: compare what the last edge produced, then drive the next one
	task automatic step(input logic rs, input logic v, input logic [13:0] op,
	                    input logic [4:0] lt, input logic ge, input logic se);
		int nf;
		@(negedge clk_i);
		if (armed)
		begin
			check("pc", pc_o, 16'(m_pc));
			check("accum", accum_o, 16'(m_acc));
			check("zero", zero_o, 16'(m_z));
			check("file_strobe", file_wr_o.strobe, 16'(m_wr));
			if (m_wr != 0)
			begin
				check("file_addr", file_wr_o.addr, 16'(m_wa));
				check("file_data", file_wr_o.data, 16'h0000);
			end
			check("push_strobe", push_o.strobe, 16'(m_push));
			if (m_push != 0)
				check("push_addr", push_o.addr, 16'(m_pa));
			check("flush", flush_o, 16'(m_fl));
			check("guard_clear", guard_clr_o, 16'(m_gc));
			check("prescale_clear", pre_clr_o, 16'(m_gc));
			check("expiry_n", expiry_n_o, 16'(m_e));
			check("powerdown_n", pdown_n_o, 16'(m_p));
		end
		armed = 1'b1;
		reset_i = rs;
		op_valid_i = v;
		opcode_i = op;
		latch_i = lt;
		expired_i = ge;
		sleep_i = se;
		m_wr = 0;
		m_push = 0;
		m_gc = 0;
		nf = 0;
		if (rs)
		begin
			m_pc = 0;
			m_acc = 0;
			m_z = 0;
			m_e = 1;
			m_p = 1;
		end
		else
		begin
			if (v && m_fl == 0)
			begin
				m_pc = (m_pc + 1) & 16'h1fff;
				if (op == 14'h0064)
				begin
					m_gc = 1;
					m_e = 1;
					m_p = 1;
				end
				else if (op[13:7] == 7'h03)
				begin
					m_wr = 1;
					m_wa = op[6:0];
					m_z = 1;
				end
				else if (op[13:7] == 7'h02)
				begin
					m_acc = 0;
					m_z = 1;
				end
				else if (op[13:11] == 3'h4)
				begin
					m_push = 1;
					m_pa = m_pc;
					nf = 1;
					m_pc = {lt[4:3], op[10:0]};
				end
			end
			if (ge)
				m_e = 0;
			if (se)
				m_p = 0;
		end
		m_fl = rs ? 0 : nf;
	endtask : step

	initial
	begin
		logic [15:0] r;
		logic [13:0] op;
		clk_i = 1'b0;
		reset_i = 1'b1;
		op_valid_i = 1'b0;
		opcode_i = 14'h0000;
		latch_i = 5'h00;
		expired_i = 1'b0;
		sleep_i = 1'b0;
		fail_count = 0;
		total_checks = 0;
		armed = 1'b0;
		seed = 16'h0019;
		repeat (12) step(1, 0, 14'h0000, 5'h00, 0, 0);
		// calls to the top of the target range on every page and to targets 0, 682, 1364, 2047, flush opcode ignored
		for (int pg = 0; pg < 4; pg++)
		begin
			step(0, 1, 14'h2000 | 14'(pg * 2047 / 3), 5'(pg << 3) | 5'h07, 0, 0);
			step(0, 1, 14'h01ff, 5'h00, 0, 0);
			step(0, 1, 14'h27ff, 5'(pg << 3), 0, 0);
			// flush slot of the second call: a guard clear here must be ignored
			step(0, 1, 14'h0064, 5'h00, 0, 0);
		end
		$display("test directed calls done");
		// events drop the flags, clear guard restores them, event wins on coincidence
		step(0, 1, 14'h0180, 5'h00, 1, 1);
		step(0, 1, 14'h0064, 5'h00, 0, 0);
		step(0, 1, 14'h0064, 5'h00, 1, 0);
		step(0, 1, 14'h0064, 5'h00, 0, 1);
		step(0, 0, 14'h0064, 5'h00, 0, 0);
		step(0, 1, 14'h017f, 5'h00, 0, 0);
		step(0, 1, 14'h00ff, 5'h00, 0, 0);
		$display("test directed clears done");
		// random mix, with a short reset in mid-run
		for (int i = 0; i < 600; i++)
		begin
			seed = lfsr_next(seed);
			r = seed;
			seed = lfsr_next(seed);
			case (r[2:0])
				3'd0: op = 14'h0180 | 14'(r[9:3]);
				3'd1: op = 14'h0100 | 14'(r[9:3]);
				3'd2: op = 14'h0064;
				3'd3, 3'd4: op = {3'h4, r[13:3]};
				default: op = r[15:2];
			endcase
			// op stays local so the pin only changes inside step, at the falling edge
			step(i == 300 || i == 301, seed[3:0] != 0, op, seed[8:4],
			     seed[12:9] == 0, seed[15:12] == 0);
		end
		step(0, 0, 14'h0000, 5'h00, 0, 0);
		$display("test random mix done");
		finish_test();
	end

endmodule : testbench

`default_nettype wire
